// File: trbhf_pkg.sv
// package: constants and carrier types for the tape read buffer write and hash filter
package trbhf_pkg;
  localparam int    CLK_MHZ         = 50;
  localparam int    DIGITS          = 12;
  localparam int    HASH_DELAY_US   = 1200;
  localparam int    HASH_DELAY_CYC  = HASH_DELAY_US * CLK_MHZ;
  localparam int    CYCLE_US        = 8;
  localparam int    CYCLE_CYC       = CYCLE_US * CLK_MHZ;
  localparam int    PHASE_CYC       = CYCLE_CYC / 8;
  localparam int    NUM_WORD_CHARS  = 12;
  localparam int    ALPHA_WORD_CHARS = 6;
  localparam int    FIFO_WIDTH      = 6;
  localparam int    FIFO_DEPTH      = 16;
  localparam logic [2:0] TRC_START_A = 3'h2;
  localparam logic [2:0] TRC_END_A   = 3'h5;
  localparam logic [2:0] TRC_START_B = 3'h6;
  localparam logic [2:0] TRC_END_B   = 3'h1;

  typedef enum logic [1:0] {TRBHF_IDLE, TRBHF_FIRST, TRBHF_SECOND} trbhf_state_t;

  typedef struct packed {
    logic       to_reg_b;
    logic [3:0] location;
    logic [5:0] data;
  } trbhf_write_t;

  typedef struct packed {
    logic parity;
    logic untranslatable;
  } trbhf_err_t;
endpackage

// File: trbhf_fifo.sv
// file: parameterised valid/ready fifo for translated characters
`timescale 1ns/10ps
module trbhf_fifo
  import trbhf_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_ptr - rd_ptr) <= (AW+1)'(DEPTH))
    else $error("fifo occupancy beyond depth");
endmodule

// File: trbhf_core.sv
// file: input buffer write-drive steering and hash-pulse filter
//
// Contract
// - word driver picks register A or B
// - no drives in check-read or checker
// - digit count decode selects one location
// - first sample at T2,3 or T6,7
// - alphanumeric second sample at T4,5 / T0,1
// - step digit counter between energizations
// - alphanumeric pair written T4,T6 or T0,T2
// - backward read fills from least digit
// - forward numeric also fills from least digit
// - forward alphanumeric fills pairs 11,12 downward
// - hash window set on start, gap
// - window cleared on first word end, or on checker digit 11 to 12 with checker
// - window errors held, not flagged
// - overskew check inhibited during window
// - 1.2 ms delay retriggered by bits
// - expiry deletes only in window, operating
// - delete clears errors, inputs, even buffer
// - delete clears digit and word counters when rw control is read
// - delete passed to checker item counter
// - held error at window end is genuine
// - read cycle on 8 us boundary, T2-T5 or T6-T1
`timescale 1ns/10ps
module trbhf_core
  import trbhf_pkg::*;
#(
  parameter int HASH_CYCLES = HASH_DELAY_CYC,
  parameter int PHASE_CYCLES = PHASE_CYC,
  parameter bit ODD_SYNC    = 1'b1
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          word_driver_set,
  input  wire logic          check_read,
  input  wire logic          checker_connected,
  input  wire logic          alphanumeric,
  input  wire logic          backward,
  input  wire logic          read_operate,
  input  wire logic          rw_control_read,
  input  wire logic          sprocket_ready,
  input  wire logic [7:0]    channel_bits,
  input  wire logic          char_valid,
  output logic               char_ready,
  input  wire logic [5:0]    char_data,
  input  wire logic          read_motion_start,
  input  wire logic          block_gap_detected,
  input  wire logic          checker_digit_11_to_12,
  input  wire trbhf_err_t    input_error,
  output logic               tape_read_cycle,
  output logic [DIGITS-1:0]  reg_a_write_drive,
  output logic [DIGITS-1:0]  reg_b_write_drive,
  output trbhf_write_t       write_word,
  output logic [3:0]         digit_count,
  output logic [3:0]         word_count,
  output logic               word_end_pulse,
  output logic               hash_window,
  output logic               overskew_check_enable,
  output logic               hash_delete,
  output logic               hash_delete_delayed,
  output logic               input_clear,
  output logic               even_buffer_clear,
  output logic               counter_clear_pulse,
  output logic               checker_item_counter_clear,
  output trbhf_err_t         window_error,
  output trbhf_err_t         diag_error,
  output logic               rw_error,
  output logic               checker_error
);
  localparam int HW = $clog2(HASH_CYCLES + 1);
  localparam int PW = $clog2(PHASE_CYCLES + 1);

  initial begin
    if (HASH_CYCLES < 2 || PHASE_CYCLES < 1) $error("timing counts too small");
  end

  function automatic logic [DIGITS-1:0] decode_digit(input logic [3:0] loc);
    decode_digit = '0;
    if (loc < 4'(DIGITS)) decode_digit[loc] = 1'b1;
  endfunction

  // ****************************************
  // phase timing: T0..T7 in an 8 us cycle
  // ****************************************
  logic [PW-1:0] phase_cnt;
  logic [2:0]    phase;
  logic          phase_tick;

  assign phase_tick = phase_cnt == PW'(PHASE_CYCLES - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt <= '0;
      phase     <= '0;
    end else if (phase_tick) begin
      phase_cnt <= '0;
      phase     <= phase + 3'h1;
    end else begin
      phase_cnt <= phase_cnt + 1'b1;
    end
  end

  // ****************************************
  // character fifo from the translator
  // ****************************************
  logic       fifo_valid;
  logic       fifo_pop;
  logic [5:0] fifo_data;

  trbhf_fifo #(.WIDTH(6), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (hash_delete),
    .in_valid  (char_valid),
    .in_ready  (char_ready),
    .in_data   (char_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ****************************************
  // tape read cycle and write sequencing
  // ****************************************
  trbhf_state_t state;
  logic [2:0]   start_phase;
  logic [2:0]   first_phase;
  logic [2:0]   second_phase;
  logic         drives_allowed;
  logic         energize;
  logic [3:0]   next_digit;
  logic [3:0]   word_len;

  assign start_phase  = ODD_SYNC ? TRC_START_A : TRC_START_B;
  // digits land two and four phases after the cycle opens
  assign first_phase  = start_phase + 3'h2;
  assign second_phase = start_phase + 3'h4;
  assign drives_allowed = !check_read && !checker_connected;
  assign word_len     = alphanumeric ? 4'(ALPHA_WORD_CHARS) : 4'(NUM_WORD_CHARS);

  // start only at a cycle boundary after a sprocket
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tape_read_cycle <= 1'b0;
    end else if (phase_tick) begin
      if (phase + 3'h1 == start_phase) tape_read_cycle <= sprocket_ready && fifo_valid;
      else if (phase + 3'h1 == start_phase + 3'h4) tape_read_cycle <= 1'b0;
    end
  end

  // first sample, then alphanumeric second sample
  assign energize = phase_tick && tape_read_cycle && fifo_valid &&
                    ((state == TRBHF_FIRST && phase + 3'h1 == first_phase) ||
                     (state == TRBHF_SECOND && phase + 3'h1 == second_phase));
  assign fifo_pop = energize;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= TRBHF_IDLE;
    end else begin
      case (state)
        TRBHF_IDLE: begin
          if (phase_tick && phase + 3'h1 == start_phase && sprocket_ready && fifo_valid) state <= TRBHF_FIRST;
        end
        TRBHF_FIRST: begin
          if (energize) state <= alphanumeric ? TRBHF_SECOND : TRBHF_IDLE;
          else if (!tape_read_cycle && phase_tick) state <= TRBHF_IDLE;
        end
        TRBHF_SECOND: begin
          if (energize || (phase_tick && !tape_read_cycle)) state <= TRBHF_IDLE;
        end
        default: state <= TRBHF_IDLE;
      endcase
    end
  end

  // digit order per mode
  always_comb begin
    next_digit = digit_count + 4'h1;
    if (!backward && alphanumeric) begin
      next_digit = digit_count[0] ? digit_count - 4'h3 : digit_count + 4'h1;
    end
  end

  logic [3:0] start_digit;
  assign start_digit = (!backward && alphanumeric) ? 4'(DIGITS - 2) : 4'h0;
  logic last_digit;
  assign last_digit = (!backward && alphanumeric) ? digit_count == 4'h1 : digit_count == 4'(DIGITS - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      digit_count <= '0;
      word_count  <= '0;
    end else if (counter_clear_pulse) begin
      digit_count <= start_digit;
      word_count  <= '0;
    end else if (read_motion_start || block_gap_detected) begin
      digit_count <= start_digit;
    end else if (energize) begin
      digit_count <= last_digit ? start_digit : next_digit;
      if (last_digit) word_count <= word_count + 4'h1;
    end
  end

  // word end on the closing character of a word
  logic [3:0] chars_in_word;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chars_in_word  <= '0;
      word_end_pulse <= 1'b0;
    end else begin
      word_end_pulse <= 1'b0;
      if (hash_delete) begin
        chars_in_word <= '0;
      end else if (energize && (state == TRBHF_FIRST)) begin
        if (chars_in_word == word_len - 4'h1) begin
          chars_in_word  <= '0;
          word_end_pulse <= 1'b1;
        end else begin
          chars_in_word <= chars_in_word + 4'h1;
        end
      end
    end
  end

  // one-hot drives gated by the word driver
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_a_write_drive <= '0;
      reg_b_write_drive <= '0;
      write_word        <= '0;
    end else begin
      reg_a_write_drive <= '0;
      reg_b_write_drive <= '0;
      if (energize && drives_allowed) begin
        if (word_driver_set) reg_b_write_drive <= decode_digit(digit_count);
        else reg_a_write_drive <= decode_digit(digit_count);
        write_word <= '{to_reg_b: word_driver_set, location: digit_count, data: fifo_data};
      end
    end
  end

  // ****************************************
  // hash window and retriggerable delay
  // ****************************************
  logic [HW-1:0] delay_cnt;
  logic          delay_expire;

  // reload on any channel bit, pulse at zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt    <= '0;
      delay_expire <= 1'b0;
    end else begin
      delay_expire <= 1'b0;
      if (|channel_bits) begin
        delay_cnt <= HW'(HASH_CYCLES);
      end else if (delay_cnt != '0) begin
        delay_cnt <= delay_cnt - 1'b1;
        if (delay_cnt == HW'(1)) delay_expire <= 1'b1;
      end
    end
  end

  logic window_end;
  assign window_end = hash_window &&
                      (checker_connected ? checker_digit_11_to_12 : word_end_pulse);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hash_window <= 1'b0;
    end else if (read_motion_start || block_gap_detected) begin
      hash_window <= 1'b1;
    end else if (window_end) begin
      hash_window <= 1'b0;
    end
  end

  assign overskew_check_enable = !hash_window;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hash_delete         <= 1'b0;
      hash_delete_delayed <= 1'b0;
    end else begin
      hash_delete         <= delay_expire && hash_window && read_operate;
      hash_delete_delayed <= hash_delete;
    end
  end

  assign input_clear                = hash_delete;
  assign counter_clear_pulse        = hash_delete && rw_control_read;
  assign checker_item_counter_clear = hash_delete && checker_connected;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      even_buffer_clear <= 1'b0;
    end else begin
      even_buffer_clear <= hash_delete;
    end
  end

  // ****************************************
  // error holding and release
  // ****************************************
  trbhf_err_t held_at_end;
  assign held_at_end = window_end ? window_error : '0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      window_error <= '0;
    end else if (hash_window && !window_end) begin
      // new error beats a delete in the same cycle
      window_error <= (hash_delete ? '0 : window_error) | input_error;
    end else begin
      window_error <= '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      diag_error    <= '0;
      rw_error      <= 1'b0;
      checker_error <= 1'b0;
    end else begin
      trbhf_err_t genuine;
      genuine = (hash_window ? '0 : input_error) | held_at_end;
      diag_error <= diag_error | genuine;
      if (|genuine) begin
        if (checker_connected) checker_error <= 1'b1;
        else rw_error <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_single_register: assert property (@(posedge clock) disable iff (!rst_n)
    !((|reg_a_write_drive) && (|reg_b_write_drive)))
    else $error("both registers driven");
  a_drive_onehot: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot0(reg_a_write_drive | reg_b_write_drive))
    else $error("more than one digit driven");
  a_inhibit_drives: assert property (@(posedge clock) disable iff (!rst_n)
    $past(check_read || checker_connected) |-> (reg_a_write_drive | reg_b_write_drive) == '0)
    else $error("drive during inhibit");
  a_digit_steps: assert property (@(posedge clock) disable iff (!rst_n)
    energize && !counter_clear_pulse && !(read_motion_start || block_gap_detected)
    |=> digit_count != $past(digit_count))
    else $error("digit count did not step");
  a_window_set: assert property (@(posedge clock) disable iff (!rst_n)
    (read_motion_start || block_gap_detected) |=> hash_window)
    else $error("window not set");
  a_delete_gated: assert property (@(posedge clock) disable iff (!rst_n)
    hash_delete |-> $past(delay_expire && hash_window && read_operate))
    else $error("delete without cause");
  sequence s_delete;
    hash_delete ##1 even_buffer_clear;
  endsequence
  a_delete_clears: assert property (@(posedge clock) disable iff (!rst_n)
    hash_delete |-> s_delete)
    else $error("even buffer not cleared");
  a_overskew_off: assert property (@(posedge clock) disable iff (!rst_n)
    hash_window |-> !overskew_check_enable)
    else $error("overskew check during window");
  a_delay_expiry: assert property (@(posedge clock) disable iff (!rst_n)
    delay_expire |-> $past(channel_bits) == '0)
    else $error("expiry right after a bit");
  a_genuine_error: assert property (@(posedge clock) disable iff (!rst_n)
    (window_end && |window_error) |=> (rw_error || checker_error))
    else $error("held error dropped at window end");
endmodule

// File: trbhf_tape_model.sv
// read bus and positioning checker model
`timescale 1ns/10ps
module trbhf_tape_model
  import trbhf_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       char_ready,
  input  wire logic       checker_item_counter_clear,
  output logic            sprocket_ready,
  output logic [7:0]      channel_bits,
  output logic            char_valid,
  output logic [5:0]      char_data,
  output logic            read_motion_start,
  output logic            block_gap_detected,
  output logic            checker_digit_11_to_12,
  output logic [7:0]      item_count
);
  logic hum = 1'b0;
  initial begin
    sprocket_ready = 1'b0;
    char_valid = 1'b0;
    char_data = 6'h2a;
    read_motion_start = 1'b0;
    block_gap_detected = 1'b0;
    checker_digit_11_to_12 = 1'b0;
  end
  // ****************
  // tasks
  // ****************
  task automatic send_char(input logic [5:0] d);
    @(negedge clock);
    char_valid = 1'b1;
    char_data = d;
    sprocket_ready = 1'b1;
    @(posedge clock);
    while (char_ready !== 1'b1) @(posedge clock);
    @(negedge clock);
    char_valid = 1'b0;
    char_data = ~d;
  endtask
  task automatic strobe(input int which);
    @(negedge clock);
    read_motion_start = (which == 0);
    block_gap_detected = (which == 1);
    checker_digit_11_to_12 = (which == 2);
    @(negedge clock);
    read_motion_start = 1'b0;
    block_gap_detected = 1'b0;
    checker_digit_11_to_12 = 1'b0;
  endtask
  // sprocket bit every 41 clocks while data runs
  always begin
    channel_bits = 8'h00;
    repeat (40) @(negedge clock);
    channel_bits = hum ? 8'h01 : 8'h00;
    @(negedge clock);
  end
  always @(posedge clock) begin
    if (checker_item_counter_clear === 1'b1) item_count <= 8'h00;
    else if (char_valid && char_ready) item_count <= item_count + 8'h01;
  end
endmodule

// File: trbhf_tb_top.sv
// self-checking testbench for the buffer write steering and hash filter
`timescale 1ns/10ps
module trbhf_tb_top
  import trbhf_pkg::*;
;
  logic clock, rst_n, word_driver_set, check_read, checker_connected, alphanumeric, backward;
  logic read_operate, rw_control_read, sprocket_ready, char_valid, char_ready, read_motion_start;
  logic block_gap_detected, checker_digit_11_to_12, tape_read_cycle, word_end_pulse, hash_window;
  logic overskew_check_enable, hash_delete, hash_delete_delayed, input_clear, even_buffer_clear;
  logic counter_clear_pulse, checker_item_counter_clear, rw_error, checker_error;
  logic [7:0] channel_bits, item_count;
  logic [5:0] char_data;
  logic [11:0] reg_a_write_drive, reg_b_write_drive;
  logic [3:0] digit_count, word_count;
  trbhf_err_t input_error, window_error, diag_error;
  trbhf_write_t write_word;
  int n_errors = 0, num_checks = 0, n_del = 0, cyc = 0;
  logic [11:0] qa[$], qb[$];
  logic [5:0] qd[$];
  logic [3:0] ql[$];
  int qt[$];
  logic qr[$];

  trbhf_core #(.HASH_CYCLES(200), .PHASE_CYCLES(2), .ODD_SYNC(1'b1)) i_dut (
    .clock                      (clock),
    .rst_n                      (rst_n),
    .word_driver_set            (word_driver_set),
    .check_read                 (check_read),
    .checker_connected          (checker_connected),
    .alphanumeric               (alphanumeric),
    .backward                   (backward),
    .read_operate               (read_operate),
    .rw_control_read            (rw_control_read),
    .sprocket_ready             (sprocket_ready),
    .channel_bits               (channel_bits),
    .char_valid                 (char_valid),
    .char_ready                 (char_ready),
    .char_data                  (char_data),
    .read_motion_start          (read_motion_start),
    .block_gap_detected         (block_gap_detected),
    .checker_digit_11_to_12     (checker_digit_11_to_12),
    .input_error                (input_error),
    .tape_read_cycle            (tape_read_cycle),
    .reg_a_write_drive          (reg_a_write_drive),
    .reg_b_write_drive          (reg_b_write_drive),
    .write_word                 (write_word),
    .digit_count                (digit_count),
    .word_count                 (word_count),
    .word_end_pulse             (word_end_pulse),
    .hash_window                (hash_window),
    .overskew_check_enable      (overskew_check_enable),
    .hash_delete                (hash_delete),
    .hash_delete_delayed        (hash_delete_delayed),
    .input_clear                (input_clear),
    .even_buffer_clear          (even_buffer_clear),
    .counter_clear_pulse        (counter_clear_pulse),
    .checker_item_counter_clear (checker_item_counter_clear),
    .window_error               (window_error),
    .diag_error                 (diag_error),
    .rw_error                   (rw_error),
    .checker_error              (checker_error)
  );
  trbhf_tape_model u_tape (
    .clock                      (clock),
    .char_ready                 (char_ready),
    .checker_item_counter_clear (checker_item_counter_clear),
    .sprocket_ready             (sprocket_ready),
    .channel_bits               (channel_bits),
    .char_valid                 (char_valid),
    .char_data                  (char_data),
    .read_motion_start          (read_motion_start),
    .block_gap_detected         (block_gap_detected),
    .checker_digit_11_to_12     (checker_digit_11_to_12),
    .item_count                 (item_count)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (hash_delete === 1'b1) n_del <= n_del + 1;
    if ((|reg_a_write_drive) || (|reg_b_write_drive)) begin
      qa.push_back(reg_a_write_drive);
      qb.push_back(reg_b_write_drive);
      ql.push_back(write_word.location);
      qd.push_back(write_word.data);
      qt.push_back(cyc);
      qr.push_back(tape_read_cycle);
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clock);
    rst_n = 1'b0;
    {word_driver_set, check_read, checker_connected, alphanumeric, backward} = 5'h00;
    {read_operate, rw_control_read} = 2'h3;
    input_error = '0;
    u_tape.hum = 1'b0;
    @(negedge clock);
    rst_n = 1'b1;
    qa.delete();
    qb.delete();
    ql.delete();
    qd.delete();
    qt.delete();
    qr.delete();
  endtask
  task automatic wait_drives(input int n);
    for (int k = 0; k < 600 && qa.size() < n; k++) @(negedge clock);
    check(qa.size(), n);
  endtask
  task automatic pulse_err(input logic par);
    @(negedge clock);
    input_error.parity = par;
    input_error.untranslatable = ~par;
    @(negedge clock);
    input_error = '0;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic test_numeric(input logic bwd);
    do_reset();
    backward = bwd;
    u_tape.hum = 1'b1;
    u_tape.strobe(0);
    check(hash_window, 1);
    pulse_err(1'b0);
    check(window_error.untranslatable, 1);
    check({rw_error, diag_error}, 0);
    for (int i = 0; i < 12; i++) u_tape.send_char(6'h01 + i[5:0]);
    wait_drives(12);
    check(write_word.to_reg_b, 0);
    check(word_count, 1);
    for (int i = 0; i < 12 && i < qa.size(); i++) begin
      check(qa[i], 12'h001 << i);
      check(qb[i], 0);
      check(qd[i], 6'h01 + i[5:0]);
      check(qr[i], 1);
      if (i > 0) check(qt[i] - qt[i-1] >= 16, 1);
    end
    repeat (8) @(negedge clock);
    check(hash_window, 0);
    check(rw_error, 1);
    check(diag_error.untranslatable, 1);
    $display("test numeric backward=%0b done", bwd);
  endtask
  task automatic test_alpha();
    int loc;
    do_reset();
    alphanumeric = 1'b1;
    word_driver_set = 1'b1;
    u_tape.hum = 1'b1;
    u_tape.strobe(0);
    for (int i = 0; i < 12; i++) u_tape.send_char(6'h10 + i[5:0]);
    wait_drives(12);
    check(write_word.to_reg_b, 1);
    for (int i = 0; i < 12 && i < qa.size(); i++) begin
      loc = 10 - 2 * (i / 2) + (i % 2);
      check(qb[i], 12'h001 << loc);
      check(qa[i], 0);
      check(ql[i], loc);
      if (i % 2) check(qt[i] - qt[i-1], 4);
    end
    repeat (8) @(negedge clock);
    check(hash_window, 0);
    $display("test alpha done");
  endtask
  task automatic test_inhibit();
    for (int k = 0; k < 2; k++) begin
      do_reset();
      check_read = (k == 0);
      checker_connected = (k == 1);
      u_tape.send_char(6'h07);
      u_tape.send_char(6'h08);
      repeat (60) @(negedge clock);
      check(qa.size(), 0);
      check(digit_count, 2);
    end
    $display("test inhibit done");
  endtask
  task automatic test_hash();
    int dels;
    do_reset();
    checker_connected = 1'b1;
    read_operate = 1'b0;
    u_tape.strobe(1);
    check(hash_window, 1);
    check(overskew_check_enable, 0);
    dels = n_del;
    u_tape.hum = 1'b1;
    repeat (45) @(negedge clock);
    u_tape.hum = 1'b0;
    repeat (300) @(negedge clock);
    check(n_del, dels);
    read_operate = 1'b1;
    u_tape.hum = 1'b1;
    pulse_err(1'b1);
    check(window_error.parity, 1);
    check(checker_error, 0);
    u_tape.send_char(6'h05);
    repeat (600) @(negedge clock);
    check(n_del, dels);
    check(digit_count, 1);
    u_tape.hum = 1'b0;
    for (int k = 0; k < 300 && hash_delete !== 1'b1; k++) @(negedge clock);
    check({hash_delete, input_clear, counter_clear_pulse}, 3'h7);
    check(checker_item_counter_clear, 1);
    @(negedge clock);
    check(even_buffer_clear, 1);
    check(hash_delete_delayed, 1);
    check({digit_count, word_count}, 0);
    check(window_error, 0);
    check(item_count, 0);
    pulse_err(1'b1);
    u_tape.strobe(2);
    repeat (2) @(negedge clock);
    check(hash_window, 0);
    check({checker_error, rw_error, diag_error.parity}, 3'h5);
    rw_control_read = 1'b0;
    u_tape.strobe(1);
    u_tape.send_char(6'h06);
    u_tape.hum = 1'b1;
    repeat (60) @(negedge clock);
    u_tape.hum = 1'b0;
    for (int k = 0; k < 300 && hash_delete !== 1'b1; k++) @(negedge clock);
    check({hash_delete, counter_clear_pulse}, 2'h2);
    repeat (2) @(negedge clock);
    check(digit_count, 1);
    $display("test hash done");
  endtask
  // ****************
  // main sequence and watchdog
  // ****************
  initial begin
    rst_n = 1'b0;
    {word_driver_set, check_read, checker_connected, alphanumeric, backward} = 5'h00;
    {read_operate, rw_control_read} = 2'h3;
    input_error = '0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    test_numeric(1'b0);
    test_numeric(1'b1);
    test_alpha();
    test_inhibit();
    test_hash();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end
endmodule
